// >>> rtl/eip_pin_irq.sv
// external interrupt pin block: status and control registers, request flag,
// event status with enables, pull device control and interrupt output
// assumes a single-cycle register port master and a pin of unknown timing
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps

// Overview of operation
// - pin events counted only while pin enabled
// - pull device on while pin enabled and pull disable clear
// - polarity selects falling/low or rising/high
// - rising polarity turns pull-up into pull-down
// - mode selects edge-only or edge-and-level
// - qualifying event sets read-only request flag
// - acknowledge one clears flag, reads zero
// - asserted level blocks acknowledge in level mode
// - interrupt raised while flag and enable set
module eip_pin_irq #(
  parameter int SYNC_STAGES = eip_pkg::SYNC_STAGES_DEF
) (
  // clock and reset
  input  wire logic                       I_REF_CLK,
  input  wire logic                       I_RST,
  // register port
  input  wire logic [eip_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [eip_pkg::DATA_W-1:0] I_WDATA,
  input  wire logic                       I_WR,
  input  wire logic                       I_RD,
  output logic      [eip_pkg::DATA_W-1:0] O_RDATA,
  // interrupt pin and pull device
  input  wire logic                       I_PIN,
  output logic                            O_PULL_EN,
  output logic                            O_PULL_UP,
  // interrupt request to the processor
  output logic                            O_IRQ
);
  import eip_pkg::*;

  typedef struct packed {
    logic              pe;
    logic              pdd;
    logic              pol;
    logic              ie;
    logic              mode;
    logic              flag;
    logic              missed;
    logic              missed_en;
    logic              pull_en;
    logic              pull_up;
    logic              irq;
    logic [DATA_W-1:0] rdata;
  } eip_core_t;

  eip_core_t q;
  eip_core_t d;

  eip_qual_if qif ();

  logic wr_ctrl;
  logic wr_clear;
  logic wr_enable;
  logic ack_hit;
  logic clr_pin;
  logic clr_missed;

  if (DATA_W != 8) begin : g_bad_width
    $error("eip_pin_irq serves an 8-bit register port only");
  end

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    reg_hit = (addr == offset);
  endfunction

  eip_pin_qual #(
    .SYNC_STAGES (SYNC_STAGES)
  ) u_qual (
    .i_clk (I_REF_CLK),
    .i_rst (I_RST),
    .i_pin (I_PIN),
    .qif   (qif.qual)
  );

  assign qif.pin_en     = q.pe;
  assign qif.polarity   = q.pol;
  assign qif.level_mode = q.mode;

  // write decode
  always_comb begin
    wr_ctrl    = I_WR && reg_hit(I_ADDR, REG_CTRL);
    wr_clear   = I_WR && reg_hit(I_ADDR, REG_EVT_CLEAR);
    wr_enable  = I_WR && reg_hit(I_ADDR, REG_EVT_ENABLE);
    ack_hit    = wr_ctrl && I_WDATA[BIT_ACK];
    clr_pin    = wr_clear && I_WDATA[EVT_PIN];
    clr_missed = wr_clear && I_WDATA[EVT_MISSED];
  end

  always_comb begin
    logic [DATA_W-1:0] rd_v;
    rd_v = RST_BYTE;
    d    = q;

    if (wr_ctrl) begin
      d.pdd  = I_WDATA[BIT_PDD];
      d.pol  = I_WDATA[BIT_POL];
      d.pe   = I_WDATA[BIT_PE];
      d.ie   = I_WDATA[BIT_IE];
      d.mode = I_WDATA[BIT_MODE];
    end
    // the pin event enable is the same bit as the flag interrupt enable
    if (wr_enable) begin
      d.ie        = I_WDATA[EVT_PIN];
      d.missed_en = I_WDATA[EVT_MISSED];
    end

    // set wins over clear; in level mode the event repeats while the pin stays asserted
    d.flag   = qif.evt | (q.flag & ~(ack_hit | clr_pin));
    // an edge that lands on a pending request cannot be counted twice
    d.missed = (qif.edge_hit & q.flag) | (q.missed & ~clr_missed);

    d.pull_en = d.pe & ~d.pdd;
    d.pull_up = ~d.pol;
    d.irq     = (d.flag & d.ie) | (d.missed & d.missed_en);

    if (I_RD) begin
      case (I_ADDR)
        REG_CTRL: begin
          rd_v[BIT_PDD]  = q.pdd;
          rd_v[BIT_POL]  = q.pol;
          rd_v[BIT_PE]   = q.pe;
          rd_v[BIT_FLAG] = q.flag;
          rd_v[BIT_ACK]  = RST_BIT;
          rd_v[BIT_IE]   = q.ie;
          rd_v[BIT_MODE] = q.mode;
        end
        REG_EVT_STATUS: begin
          rd_v[EVT_PIN]    = q.flag;
          rd_v[EVT_MISSED] = q.missed;
        end
        REG_EVT_ENABLE: begin
          rd_v[EVT_PIN]    = q.ie;
          rd_v[EVT_MISSED] = q.missed_en;
        end
        default: begin
          rd_v = RST_BYTE;
        end
      endcase
    end
    // read data stand for one cycle only, zero otherwise
    d.rdata = rd_v;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign O_RDATA   = q.rdata;
  assign O_PULL_EN = q.pull_en;
  assign O_PULL_UP = q.pull_up;
  assign O_IRQ     = q.irq;

  pin_disabled_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    !q.pe |=> !qif.evt)
    else $error("event raised while the pin function was disabled");

  pull_enable_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    wr_ctrl |=> (O_PULL_EN == ($past(I_WDATA[BIT_PE]) && !$past(I_WDATA[BIT_PDD]))))
    else $error("pull device enable does not follow the written control");

  pull_stable_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (!I_WR ##1 !I_WR) |-> $stable(O_PULL_EN))
    else $error("pull device enable changed without a register write");

  pull_down_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (wr_ctrl && I_WDATA[BIT_POL]) |=> !O_PULL_UP)
    else $error("rising polarity kept the pull-up");

  pull_up_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (wr_ctrl && !I_WDATA[BIT_POL]) |=> O_PULL_UP)
    else $error("falling polarity did not select the pull-up");

  flag_set_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    qif.evt |=> q.flag)
    else $error("request flag missed a qualified event");

  flag_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (q.flag && !ack_hit && !clr_pin) |=> q.flag)
    else $error("request flag dropped without an acknowledge");

  flag_no_cause_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (!q.flag && !qif.evt) |=> !q.flag)
    else $error("request flag set without an event");

  ack_clear_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (wr_ctrl && I_WDATA[BIT_ACK] && !qif.evt) |=> !q.flag)
    else $error("acknowledge write did not clear the request flag");

  ack_reads_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_RD && reg_hit(I_ADDR, REG_CTRL)) |=> !O_RDATA[BIT_ACK])
    else $error("acknowledge bit read back as one");

  flag_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_RD && reg_hit(I_ADDR, REG_CTRL)) |=> (O_RDATA[BIT_FLAG] == $past(q.flag)))
    else $error("request flag read back wrong");

  level_block_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ($past(q.pe && q.mode) && qif.lvl && q.flag) |=> q.flag)
    else $error("acknowledge cleared the flag while the pin stayed asserted");

  irq_raise_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (qif.evt && q.ie && !wr_ctrl && !wr_enable) |=> O_IRQ)
    else $error("no interrupt for a pending request with the enable set");

  irq_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (!q.ie && !q.missed_en && !I_WR) |=> !O_IRQ)
    else $error("interrupt raised with all enables clear");

  read_window_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    !I_RD |=> (O_RDATA == RST_BYTE))
    else $error("read data stood outside the read cycle");

  missed_set_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (qif.edge_hit && q.flag) |=> q.missed)
    else $error("edge on a pending request did not set the missed event");

  missed_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (q.missed && !clr_missed) |=> q.missed)
    else $error("missed event dropped without a clear");

  missed_no_cause_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (!q.missed && !(qif.edge_hit && q.flag)) |=> !q.missed)
    else $error("missed event set without an edge on a pending request");

  clear_pin_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (clr_pin && !qif.evt) |=> !q.flag)
    else $error("event clear write did not clear the request flag");

  status_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_RD && reg_hit(I_ADDR, REG_EVT_STATUS)) |=>
      ((O_RDATA[EVT_PIN] == $past(q.flag)) && (O_RDATA[EVT_MISSED] == $past(q.missed))))
    else $error("event status read back wrong");

  enable_read_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_RD && reg_hit(I_ADDR, REG_EVT_ENABLE)) |=>
      ((O_RDATA[EVT_PIN] == $past(q.ie)) && (O_RDATA[EVT_MISSED] == $past(q.missed_en))))
    else $error("event enable read back wrong");

  clear_reads_zero_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_RD && reg_hit(I_ADDR, REG_EVT_CLEAR)) |=> (O_RDATA == RST_BYTE))
    else $error("event clear register did not read zero");

  ctrl_write_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    wr_ctrl |=> ((q.pe == $past(I_WDATA[BIT_PE])) && (q.mode == $past(I_WDATA[BIT_MODE]))))
    else $error("control write did not land");

  pull_off_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    !q.pe |-> !O_PULL_EN)
    else $error("pull device on while the pin function was disabled");

  pull_dir_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    q.pol |-> !O_PULL_UP)
    else $error("pull-up kept with rising polarity");

  irq_flag_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (q.flag && q.ie) |-> O_IRQ)
    else $error("pending enabled request without an interrupt");

  irq_missed_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (q.missed && q.missed_en) |-> O_IRQ)
    else $error("enabled missed event without an interrupt");

endmodule

// >>> rtl/eip_pkg.sv
// constants shared by the external interrupt pin block and its pin qualifier
// assumes an 8-bit register port with a 2-bit word address
package eip_pkg;

  // register port widths
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL       = 2'h0;
  localparam logic [ADDR_W-1:0] REG_EVT_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] REG_EVT_CLEAR  = 2'h2;
  localparam logic [ADDR_W-1:0] REG_EVT_ENABLE = 2'h3;

  // bit positions of the status and control register
  localparam int BIT_MODE = 0;
  localparam int BIT_IE   = 1;
  localparam int BIT_ACK  = 2;
  localparam int BIT_FLAG = 3;
  localparam int BIT_PE   = 4;
  localparam int BIT_POL  = 5;
  localparam int BIT_PDD  = 6;

  // bit positions of the event status, clear and enable registers
  localparam int EVT_PIN    = 0;
  localparam int EVT_MISSED = 1;

  // reset values
  localparam logic        RST_BIT  = 1'h0;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  // synchroniser starts at the pulled-up idle level, so no false level follows reset
  localparam logic        RST_PIN_IDLE = 1'h1;

  // default synchroniser depth
  localparam int SYNC_STAGES_DEF = 2;

endpackage

// >>> rtl/eip_qual_if.sv
// carrier between the register core and the pin qualifier
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface eip_qual_if;
  logic pin_en;
  logic polarity;
  logic level_mode;
  logic evt;
  logic edge_hit;
  logic lvl;

  // register core side
  modport ctrl (
    output pin_en, polarity, level_mode,
    input  evt, edge_hit, lvl
  );

  // qualifier side
  modport qual (
    input  pin_en, polarity, level_mode,
    output evt, edge_hit, lvl
  );
endinterface

// >>> rtl/eip_pin_qual.sv
// pin synchroniser with edge and level qualification
// assumes the pin is asynchronous to the clock; settings come from the core
`timescale 1ns/1ps
module eip_pin_qual #(
  parameter int SYNC_STAGES = eip_pkg::SYNC_STAGES_DEF
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // pin
  input  wire logic i_pin,
  // settings and events
  eip_qual_if.qual  qif
);
  import eip_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic                   prev;
    logic                   lvl;
    logic                   edge_hit;
    logic                   evt;
  } eip_qual_t;

  eip_qual_t q;
  eip_qual_t d;

  if (SYNC_STAGES < 2) begin : g_bad_depth
    $error("eip_pin_qual needs at least two synchroniser stages");
  end

  always_comb begin
    logic s;
    logic asserted;
    logic prev_as;
    s        = q.sync[SYNC_STAGES-1];
    asserted = qif.polarity ? s : ~s;
    // previous sample judged with today's polarity, so a polarity write makes no edge
    prev_as  = qif.polarity ? q.prev : ~q.prev;
    d          = q;
    d.sync     = {q.sync[SYNC_STAGES-2:0], i_pin};
    d.prev     = s;
    d.lvl      = asserted;
    d.edge_hit = qif.pin_en & asserted & ~prev_as;
    d.evt      = qif.pin_en & ((asserted & ~prev_as) | (qif.level_mode & asserted));
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '{sync:     {SYNC_STAGES{RST_PIN_IDLE}},
             prev:     RST_PIN_IDLE,
             lvl:      RST_BIT,
             edge_hit: RST_BIT,
             evt:      RST_BIT};
    end else begin
      q <= d;
    end
  end

  assign qif.evt      = q.evt;
  assign qif.edge_hit = q.edge_hit;
  assign qif.lvl      = q.lvl;

  edge_only_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (qif.evt && !$past(qif.level_mode)) |-> qif.edge_hit)
    else $error("edge-only mode raised an event without an edge");

  level_event_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(qif.pin_en && qif.level_mode) && qif.lvl) |-> qif.evt)
    else $error("asserted level in level mode gave no event");

  sync_delay_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(qif.evt) |-> ($past(i_pin, SYNC_STAGES + 1) == $past(qif.polarity)))
    else $error("event does not match the pin sample through the synchroniser");

  pol_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
    qif.lvl |-> ($past(i_pin, SYNC_STAGES + 1) == $past(qif.polarity)))
    else $error("asserted level does not follow the polarity select");

endmodule

// >>> verification/eip_pin_src.sv
// external interrupt source model standing on the pin
// assumes the bench sets drive enable and level just after a clock edge
`timescale 1ns/1ps
module eip_pin_src (
  // drive request from the bench
  input  wire logic i_drv_en,
  input  wire logic i_drv_val,
  // pull device state seen on the pin
  input  wire logic i_pull_en,
  input  wire logic i_pull_up,
  // pin
  output logic      o_pin
);
  logic last_val;

  initial last_val = 1'b0;

  always @(i_drv_en or i_drv_val) begin
    if (i_drv_en) begin
      last_val = i_drv_val;
    end
  end

  // released pin: pull level if on, else inverse of last level so no stale value hides
  assign o_pin = i_drv_en ? i_drv_val : (i_pull_en ? i_pull_up : ~last_val);
endmodule

// >>> verification/eip_pin_irq_tb.sv
// self-checking bench for the external interrupt pin block
// assumes the pin source model and the register port contract of the block
`timescale 1ns/1ps
module eip_pin_irq_tb;
  import eip_pkg::*;
  logic              clk;
  logic              rst;
  logic              wr;
  logic              rd;
  logic              drv_en;
  logic              drv_val;
  logic              pin;
  logic              pull_en;
  logic              pull_up;
  logic              irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  int                err_count;
  int                n_compared;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  eip_pin_irq uut (.I_REF_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_PIN(pin), .O_PULL_EN(pull_en), .O_PULL_UP(pull_up),
    .O_IRQ(irq));
  eip_pin_src src (.i_drv_en(drv_en), .i_drv_val(drv_val), .i_pull_en(pull_en),
    .i_pull_up(pull_up), .o_pin(pin));

  task automatic stop_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // five edges cover the synchroniser and event register latency
  task automatic pin_set(input logic v);
    @(posedge clk);
    drv_val <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rd_chk(REG_CTRL, 8'h00);
    chk({5'h00, pull_en, pull_up, irq}, 8'h02);
  endtask

  task automatic t_disabled;
    wr_reg(REG_CTRL, 8'h02);
    pin_set(1'b0);
    rd_chk(REG_CTRL, 8'h02);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_pull;
    wr_reg(REG_CTRL, 8'h10);
    chk({6'h00, pull_en, pull_up}, 8'h03);
    wr_reg(REG_CTRL, 8'h30);
    chk({6'h00, pull_en, pull_up}, 8'h02);
    wr_reg(REG_CTRL, 8'h70);
    chk({7'h00, pull_en}, 8'h00);
  endtask

  task automatic t_edge;
    wr_reg(REG_CTRL, 8'h12);
    pin_set(1'b1);
    rd_chk(REG_CTRL, 8'h12);
    @(posedge clk);
    drv_val <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd_chk(REG_CTRL, 8'h1a);
    wr_reg(REG_CTRL, 8'h12);
    rd_chk(REG_CTRL, 8'h1a);
    wr_reg(REG_CTRL, 8'h16);
    rd_chk(REG_CTRL, 8'h12);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_polled;
    wr_reg(REG_CTRL, 8'h10);
    pin_set(1'b1);
    pin_set(1'b0);
    rd_chk(REG_CTRL, 8'h18);
    chk({7'h00, irq}, 8'h00);
    wr_reg(REG_CTRL, 8'h14);
    rd_chk(REG_CTRL, 8'h10);
  endtask

  task automatic t_level;
    wr_reg(REG_CTRL, 8'h30);
    pin_set(1'b1);
    wr_reg(REG_CTRL, 8'h34);
    rd_chk(REG_CTRL, 8'h30);
    pin_set(1'b0);
    wr_reg(REG_CTRL, 8'h31);
    pin_set(1'b1);
    wr_reg(REG_CTRL, 8'h35);
    rd_chk(REG_CTRL, 8'h39);
    pin_set(1'b0);
    wr_reg(REG_CTRL, 8'h35);
    rd_chk(REG_CTRL, 8'h31);
  endtask

  // second falling edge while the flag is pending sets the missed event
  task automatic t_events;
    wr_reg(REG_CTRL, 8'h12);
    pin_set(1'b1);
    pin_set(1'b0);
    pin_set(1'b1);
    pin_set(1'b0);
    rd_chk(REG_EVT_STATUS, 8'h03);
    wr_reg(REG_EVT_ENABLE, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr_reg(REG_EVT_ENABLE, 8'h02);
    chk({7'h00, irq}, 8'h01);
    rd_chk(REG_EVT_ENABLE, 8'h02);
    wr_reg(REG_EVT_CLEAR, 8'h02);
    chk({7'h00, irq}, 8'h00);
    rd_chk(REG_EVT_CLEAR, 8'h00);
    wr_reg(REG_EVT_CLEAR, 8'h01);
    rd_chk(REG_EVT_STATUS, 8'h00);
  endtask

  // released pin follows the pull device; with the pull off the far side swings it
  task automatic t_release;
    wr_reg(REG_CTRL, 8'h10);
    @(posedge clk);
    drv_en <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rd_chk(REG_CTRL, 8'h10);
    wr_reg(REG_CTRL, 8'h30);
    repeat (5) @(posedge clk);
    #1;
    rd_chk(REG_CTRL, 8'h30);
    wr_reg(REG_CTRL, 8'h70);
    repeat (5) @(posedge clk);
    #1;
    rd_chk(REG_CTRL, 8'h78);
    wr_reg(REG_CTRL, 8'h74);
    rd_chk(REG_CTRL, 8'h70);
  endtask

  // reset in mid-run with a pending request
  task automatic t_midreset;
    wr_reg(REG_CTRL, 8'h73);
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({5'h00, pull_en, pull_up, irq}, 8'h02);
    rd_chk(REG_CTRL, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    drv_en = 1'b1;
    drv_val = 1'b1;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_disabled();
    t_pull();
    t_edge();
    t_polled();
    t_level();
    t_events();
    t_release();
    t_midreset();
    stop_test();
  end

  // whole run takes about two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule
